// ===== core/psc_host.sv
// Host controller that drives an asynchronous pseudo-SRAM through its pins.
`timescale 1ns/1ns
`default_nettype none
module psc_host
#(
    parameter int DENSITY  = 64,                    // Part size in Mb.
    parameter int CHH_CYC  = psc_pkg::CHH_CYC_DEF,  // Select high after exit.
    parameter int C2LH_CYC = psc_pkg::C2LH_CYC_DEF  // Sleep low at power-up.
)
(
    input  wire logic                        clock,              // 250 MHz.
    input  wire logic                        reset,              // Sync, high.
    input  wire logic                        reqValid,           // Request.
    output logic                             reqReady,           // Taken.
    input  wire logic                        reqWrite,           // 1 = write.
    input  wire logic [psc_pkg::ADDR_W-1:0]  reqAddr,            // Word addr.
    input  wire logic [psc_pkg::DATA_W-1:0]  reqData,            // Write data.
    input  wire logic [1:0]                  reqByteEn,          // Lanes.
    output logic                             respValid,          // Read pulse.
    output logic [psc_pkg::DATA_W-1:0]       respData,           // Read data.
    input  wire logic                        sleepReq,           // Enter sleep.
    input  wire logic                        wakeReq,            // Leave sleep.
    input  wire logic                        partialMode,        // Retention.
    output logic                             idle,               // Accepts.
    output logic                             asleep,             // Powered down.
    output logic [psc_pkg::ADDR_W-1:0]       memAddr,            // Address pins.
    output logic                             primarySelectN,     // Chip select.
    output logic                             sleepControlSelect, // Sleep pin.
    output logic                             outputEnableN,      // Output en.
    output logic                             writeEnableN,       // Write en.
    output logic                             lowByteSelectN,     // Low lane.
    output logic                             highByteSelectN,    // High lane.
    output logic [psc_pkg::DATA_W-1:0]       dqOut,              // Data out.
    output logic                             dqOe,               // Drive data.
    input  wire logic [psc_pkg::DATA_W-1:0]  dqIn                // Data in.
);
    import psc_pkg::*;

    localparam int CW = 17;
    // Per-density selection of the RC, WP, CP, C2LP and WHOL counts.
    localparam int RC_C   = (DENSITY == 16) ? RC_CYC_16 : RC_CYC;
    localparam int WP_C   = (DENSITY == 16) ? WP_CYC_16 : WP_CYC;
    localparam int CP_C   = (DENSITY == 16) ? CP_CYC_16 : CP_CYC;
    localparam int C2LP_C = (DENSITY == 16) ? C2LP_CYC_16 : C2LP_CYC;
    localparam int WHOL_C = (DENSITY == 16) ? WHOL_CYC_16 :
                            (DENSITY == 32) ? WHOL_CYC_32 : WHOL_CYC_64;
    localparam int SEL_C  = (HOLD_CYC < BURST_CYC) ? HOLD_CYC : BURST_CYC;
    localparam int REC_C  = RC_C - 1 - WP_C;
    localparam logic [CW-1:0] ASO_L  = CW'(ASO_CYC - 1);
    localparam logic [CW-1:0] RDACC_L = CW'(RC_C - ASO_CYC - 1);
    localparam logic [CW-1:0] PRC_L  = CW'(PRC_CYC - 1);
    localparam logic [CW-1:0] WP_L   = CW'(WP_C - 1);
    localparam logic [CW-1:0] REC_L  = CW'(REC_C - 1);
    localparam logic [CW-1:0] CP_L   = CW'(CP_C - 1);
    localparam logic [CW-1:0] CSP_L  = CW'(CSP_CYC - 1);
    localparam logic [CW-1:0] C2LP_L = CW'(C2LP_C - 1);
    localparam logic [CW-1:0] CHH_L  = CW'(CHH_CYC - 1);
    localparam logic [CW-1:0] CHHP_L = CW'(CHHP_CYC - 1);
    localparam logic [CW-1:0] C2LH_L = CW'(C2LH_CYC - 1);
    localparam logic [CW-1:0] SEL_L  = CW'(SEL_C - 1);
    localparam logic [CW-1:0] PGLIM  = CW'(SEL_C - PRC_CYC - 3);
    localparam logic [3:0]    WHOL_L = 4'(WHOL_C);

    // Refuse settings the counters or sequences cannot serve.
    if (!(DENSITY == 16 || DENSITY == 32 || DENSITY == 64))
        $error("DENSITY must be 16, 32 or 64");
    if (CHH_CYC < 1 || CHH_CYC >= 2 ** CW || C2LH_CYC < 1
        || C2LH_CYC >= 2 ** CW)
        $error("power-up counts out of counter range");
    if (REC_C < CHWX_CYC || WHOL_C > 15)
        $error("write recovery too short for the select hold");

    psc_state_t               state;
    logic [CW-1:0]            cnt;
    logic [CW-1:0]            selCnt;
    logic [3:0]               wrGapCnt;
    logic                     pageOk;
    logic                     samePage;
    logic [1:0]               reqByteEnR;

    ////////////////////////////////////////////////////////////////////////
    // Page access only on parts that have it, same upper address, and with
    // time left before the select-low limit.
    assign samePage = (reqAddr[ADDR_W-1:PAGE_BITS]
                       == memAddr[ADDR_W-1:PAGE_BITS]);
    assign pageOk   = (DENSITY != 16) && !reqWrite && samePage
                      && (selCnt < PGLIM);
    assign reqReady = (state == ST_IDLE)
                      || (state == ST_RD_HOLD && reqValid && pageOk);
    assign idle     = (state == ST_IDLE);
    assign asleep   = (state == ST_PD_LOW);

    ////////////////////////////////////////////////////////////////////////
    // Main sequencer; the timed phases share one counter, while selCnt bounds the read hold.
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            state <= ST_PWRUP_LOW;
            cnt   <= '0;
        end
        else
        begin
            cnt <= cnt + 1'b1;
            case (state)
                ST_PWRUP_LOW:
                    if (cnt == C2LH_L)
                    begin
                        state <= ST_PWRUP_WAIT;
                        cnt   <= '0;
                    end
                ST_PWRUP_WAIT:
                    if (cnt == CHH_L)
                        state <= ST_IDLE;
                ST_IDLE:
                begin
                    cnt <= '0;
                    if (reqValid)
                        state <= reqWrite ? ST_WR_SETUP : ST_RD_ADDR;
                    else if (sleepReq)
                        state <= ST_PD_SETUP;
                end
                ST_RD_ADDR:
                    if (cnt >= ASO_L && wrGapCnt == 4'h0)
                    begin
                        state <= ST_RD_ACC;
                        cnt   <= '0;
                    end
                ST_RD_ACC:
                    // Address held for the full read cycle.
                    if (cnt == RDACC_L)
                        state <= ST_RD_HOLD;
                ST_RD_HOLD:
                begin
                    cnt <= '0;
                    if (reqValid && pageOk)
                        state <= ST_PG_ACC;
                    else if (reqValid || sleepReq || selCnt >= PGLIM)
                        state <= ST_DESEL;
                end
                ST_PG_ACC:
                    if (cnt == PRC_L)
                    begin
                        state <= ST_RD_HOLD;
                        cnt   <= '0;
                    end
                ST_WR_SETUP:
                begin
                    state <= ST_WR_PULSE;
                    cnt   <= '0;
                end
                ST_WR_PULSE:
                    if (cnt == WP_L)
                    begin
                        state <= ST_WR_REC;
                        cnt   <= '0;
                    end
                ST_WR_REC:
                    if (cnt == REC_L)
                    begin
                        state <= ST_DESEL;
                        cnt   <= '0;
                    end
                ST_DESEL:
                    if (cnt == CP_L)
                        state <= ST_IDLE;
                ST_PD_SETUP:
                    if (cnt == CSP_L)
                    begin
                        state <= ST_PD_LOW;
                        cnt   <= '0;
                    end
                ST_PD_LOW:
                    if (cnt >= C2LP_L && wakeReq)
                    begin
                        state <= ST_PD_EXIT;
                        cnt   <= '0;
                    end
                    else if (cnt >= C2LP_L)
                        cnt <= cnt;
                ST_PD_EXIT:
                    if (cnt == (partialMode ? CHHP_L : CHH_L))
                        state <= ST_IDLE;
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Time spent with the select low, bounding bursts and long holds.
    always_ff @(posedge clock)
    begin
        if (reset || primarySelectN)
            selCnt <= '0;
        else if (selCnt != SEL_L)
            selCnt <= selCnt + 1'b1;
    end

    // Gap from write enable rising to the next output enable fall.
    always_ff @(posedge clock)
    begin
        if (reset)
            wrGapCnt <= 4'h0;
        else if (state == ST_WR_PULSE)
            wrGapCnt <= WHOL_L;
        else if (wrGapCnt != 4'h0)
            wrGapCnt <= wrGapCnt - 4'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drive; all pins come from flip-flops so edges are glitch free.
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            memAddr            <= '0;
            primarySelectN     <= 1'b1;
            sleepControlSelect <= 1'b0;
            outputEnableN      <= 1'b1;
            writeEnableN       <= 1'b1;
            lowByteSelectN     <= 1'b1;
            highByteSelectN    <= 1'b1;
            dqOut              <= '0;
            dqOe               <= 1'b0;
        end
        else
        begin
            case (state)
                ST_PWRUP_LOW:
                    sleepControlSelect <= (cnt == C2LH_L);
                ST_IDLE:
                    if (reqValid)
                    begin
                        // Output enable is already high here.
                        memAddr         <= reqAddr;
                        primarySelectN  <= 1'b0;
                        dqOut           <= reqData;
                        lowByteSelectN  <= 1'b1;
                        highByteSelectN <= 1'b1;
                    end
                ST_RD_ADDR:
                    if (cnt >= ASO_L && wrGapCnt == 4'h0)
                    begin
                        outputEnableN   <= 1'b0;
                        lowByteSelectN  <= ~reqByteEnR[0];
                        highByteSelectN <= ~reqByteEnR[1];
                    end
                ST_RD_HOLD:
                    if (reqValid && pageOk)
                    begin
                        memAddr[PAGE_BITS-1:0] <= reqAddr[PAGE_BITS-1:0];
                        lowByteSelectN  <= ~reqByteEn[0];
                        highByteSelectN <= ~reqByteEn[1];
                    end
                    else if (reqValid || sleepReq || selCnt >= PGLIM)
                    begin
                        primarySelectN  <= 1'b1;
                        outputEnableN   <= 1'b1;
                        lowByteSelectN  <= 1'b1;
                        highByteSelectN <= 1'b1;
                    end
                ST_WR_SETUP:
                begin
                    // Enabled lanes fall together so their pulses overlap fully.
                    writeEnableN    <= 1'b0;
                    lowByteSelectN  <= ~reqByteEnR[0];
                    highByteSelectN <= ~reqByteEnR[1];
                    dqOe            <= 1'b1;
                end
                ST_WR_PULSE:
                    if (cnt == WP_L)
                    begin
                        writeEnableN    <= 1'b1;
                        lowByteSelectN  <= 1'b1;
                        highByteSelectN <= 1'b1;
                    end
                ST_WR_REC:
                    if (cnt == REC_L)
                    begin
                        // Write enable rose long before; it stays high.
                        primarySelectN <= 1'b1;
                        dqOe           <= 1'b0;
                    end
                ST_PD_SETUP:
                    if (cnt == CSP_L)
                        sleepControlSelect <= 1'b0;
                ST_PD_LOW:
                    if (cnt >= C2LP_L && wakeReq)
                        sleepControlSelect <= 1'b1;
                default:
                    dqOe <= dqOe;
            endcase
        end
    end

    // Byte enables and the read result.
    always_ff @(posedge clock)
    begin
        if (reset)
            reqByteEnR <= 2'h0;
        else if (state == ST_IDLE && reqValid)
            reqByteEnR <= reqByteEn;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            respValid <= 1'b0;
            respData  <= '0;
        end
        else
        begin
            respValid <= (state == ST_RD_ACC && cnt == RDACC_L)
                         || (state == ST_PG_ACC && cnt == PRC_L);
            if ((state == ST_RD_ACC && cnt == RDACC_L)
                || (state == ST_PG_ACC && cnt == PRC_L))
                respData <= dqIn;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    a_write_pulse_len: assert property ($fell(writeEnableN) |->
        !writeEnableN [*8]) else $error("write pulse short");
    a_select_high_gap: assert property ($rose(primarySelectN) |->
        primarySelectN [*3]) else $error("select high short");
    a_write_oe_high: assert property (!writeEnableN |-> outputEnableN)
        else $error("output enable low in write");
    a_we_at_deselect: assert property ($rose(primarySelectN) |->
        writeEnableN && $past(writeEnableN, 3))
        else $error("write enable moved at deselect");
    a_read_after_write: assert property ($fell(outputEnableN) |->
        wrGapCnt == 4'h0) else $error("read too soon after write");
    a_mask_stable: assert property (!writeEnableN && $past(!writeEnableN)
        |-> $stable({lowByteSelectN, highByteSelectN}))
        else $error("byte mask moved in pulse");
    a_select_low_limit: assert property (selCnt < SEL_L)
        else $error("select low too long");
    a_sleep_low_hold: assert property ($fell(sleepControlSelect) |->
        !sleepControlSelect [*8]) else $error("sleep low short");
    a_exit_select_high: assert property ($rose(sleepControlSelect) |->
        primarySelectN ##1 primarySelectN [*8])
        else $error("select low at exit");
    a_read_addr_hold: assert property (state == ST_RD_ACC
        && $past(state) == ST_RD_ACC |-> $stable(memAddr))
        else $error("address moved in read");
    a_page_data_time: assert property (state == ST_PG_ACC
        && $past(state) == ST_RD_HOLD |-> ##5 respValid)
        else $error("page word late");

    c_read_done:  cover property (state == ST_RD_ACC ##[1:40] respValid);
    c_page_read:  cover property (state == ST_PG_ACC ##[1:10] respValid);
    c_write_done: cover property ($fell(writeEnableN) ##[1:40]
                                  $rose(primarySelectN));
    c_sleep_exit: cover property ($fell(sleepControlSelect) ##[1:500]
                                  $rose(sleepControlSelect));

endmodule
`default_nettype wire

// ===== core/psc_pkg.sv
// Constants, timing counts and types for the pseudo-SRAM host controller.
// Functional notes
// - Random address is held for at least one read cycle, 65 or 70 ns.
// - Select held low without upper address change ends within 1000 ns.
// - A page-read burst is closed by deselect within 4 us of its start.
// - Write cycle spans setup, pulse and recovery, at least 65 ns.
// - Write with select low and no address change ends within 1000 ns.
// - Output enable is high before a new write address is presented.
// - Byte masks stay stable through the write pulse; they change on the same edges as write enable.
// - Both byte select pulses of a write overlap at least 30 ns.
// - Primary select stays high 12 ns, 10 ns for 16 Mb, between accesses.
// - Sleep select falls 10 ns after setup and stays low 65 or 80 ns.
// - Primary select stays high 300 us after sleep exit and power-up.
// - With partial retention, primary select stays high only 1 us on exit.
// - Primary select is already high when sleep select rises.
// - Sleep select is held low 50 us after power-up before rising.
// - Write enable stays stable 10 ns after primary select rises.
package psc_pkg;

    localparam int CLK_PERIOD_PS = 4000;

    // Least times round up, longest times round down; never below one cycle.
    function automatic int cyc_up(input int ps);
        int c;
        c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int cyc_dn(input int ps);
        int c;
        c = ps / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    // Times in their printed units.
    localparam int T_RC_NS_16    = 70;
    localparam int T_RC_NS       = 65;
    localparam int T_ASO_NS      = 10;
    localparam int T_PRC_NS      = 20;
    localparam int T_WP_NS_16    = 45;
    localparam int T_WP_NS       = 40;
    localparam int T_CP_NS_16    = 10;
    localparam int T_CP_NS       = 12;
    localparam int T_WHOL_NS_16  = 10;
    localparam int T_WHOL_NS_32  = 12;
    localparam int T_WHOL_NS_64  = 25;
    localparam int T_CHWX_NS     = 10;
    localparam int T_CSP_NS      = 10;
    localparam int T_C2LP_NS_16  = 80;
    localparam int T_C2LP_NS     = 65;
    localparam int T_HOLD_MAX_NS = 1000;
    localparam int T_BURST_US    = 4;
    localparam int T_CHH_US      = 300;
    localparam int T_CHHP_US     = 1;
    localparam int T_C2LH_US     = 50;

    // Cycle counts derived from the times.
    localparam int RC_CYC_16   = cyc_up(T_RC_NS_16 * 1000);
    localparam int RC_CYC      = cyc_up(T_RC_NS * 1000);
    localparam int ASO_CYC     = cyc_up(T_ASO_NS * 1000);
    localparam int PRC_CYC     = cyc_up(T_PRC_NS * 1000);
    localparam int WP_CYC_16   = cyc_up(T_WP_NS_16 * 1000);
    localparam int WP_CYC      = cyc_up(T_WP_NS * 1000);
    localparam int CP_CYC_16   = cyc_up(T_CP_NS_16 * 1000);
    localparam int CP_CYC      = cyc_up(T_CP_NS * 1000);
    localparam int WHOL_CYC_16 = cyc_up(T_WHOL_NS_16 * 1000);
    localparam int WHOL_CYC_32 = cyc_up(T_WHOL_NS_32 * 1000);
    localparam int WHOL_CYC_64 = cyc_up(T_WHOL_NS_64 * 1000);
    localparam int CHWX_CYC    = cyc_up(T_CHWX_NS * 1000);
    localparam int CSP_CYC     = cyc_up(T_CSP_NS * 1000);
    localparam int C2LP_CYC_16 = cyc_up(T_C2LP_NS_16 * 1000);
    localparam int C2LP_CYC    = cyc_up(T_C2LP_NS * 1000);
    localparam int HOLD_CYC    = cyc_dn(T_HOLD_MAX_NS * 1000);
    localparam int BURST_CYC   = cyc_dn(T_BURST_US * 1000000);
    localparam int CHH_CYC_DEF = cyc_up(T_CHH_US * 1000000);
    localparam int CHHP_CYC    = cyc_up(T_CHHP_US * 1000000);
    localparam int C2LH_CYC_DEF = cyc_up(T_C2LH_US * 1000000);

    localparam int ADDR_W    = 22;
    localparam int DATA_W    = 16;
    localparam int PAGE_BITS = 3;

    typedef enum logic [3:0] {
        ST_PWRUP_LOW,
        ST_PWRUP_WAIT,
        ST_IDLE,
        ST_RD_ADDR,
        ST_RD_ACC,
        ST_RD_HOLD,
        ST_PG_ACC,
        ST_WR_SETUP,
        ST_WR_PULSE,
        ST_WR_REC,
        ST_DESEL,
        ST_PD_SETUP,
        ST_PD_LOW,
        ST_PD_EXIT
    } psc_state_t;

endpackage

// ===== core/psc_host_fix.sv
// Holds no logic; the whole host controller lives in psc_host.

// ===== tb/psc_psram_model.sv
// Behavioural pseudo-SRAM that answers the host controller's pins.
`timescale 1ns/1ns
`default_nettype none
module psc_psram_model
(
    input  wire logic [21:0] addr,  // Address pins.
    input  wire logic        selN,  // Primary select.
    input  wire logic        sleep, // Sleep select.
    input  wire logic        oeN,   // Output enable.
    input  wire logic        weN,   // Write enable.
    input  wire logic        lbN,   // Low lane select.
    input  wire logic        hbN,   // High lane select.
    input  wire logic [15:0] din,   // Data from the host.
    output wire logic [15:0] dq     // Data to the host.
);
    logic [15:0] mem [0:63];
    logic [15:0] last;
    wire         rd = !selN && !oeN && sleep && weN;
    wire         lo = rd && !lbN;
    wire         hi = rd && !hbN;

    ////////////////////////////////////////////////////////////////////////
    // Upper address bits alias into a small array to keep the model cheap.
    always @*
        if (!selN && !weN && oeN && sleep)
        begin
            if (!lbN) mem[addr[5:0]][7:0] = din[7:0];
            if (!hbN) mem[addr[5:0]][15:8] = din[15:8];
        end

    // Data lands 19 ns after a change, inside the page access limit, so a
    // sample on the 20 ns edge is never a race; an undriven lane toggles.
    assign #19 dq[7:0] = lo ? mem[addr[5:0]][7:0] : ~last[7:0];
    assign #19 dq[15:8] = hi ? mem[addr[5:0]][15:8] : ~last[15:8];
    always @(dq)
        last = dq;
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the pseudo-SRAM host controller.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import psc_pkg::*;
    localparam int CHH = 20;
    localparam int C2LH = 20;
    localparam int BIG = 1 << 30;
    logic        clock, reset, reqValid, reqReady, reqWrite, respValid;
    logic        sleepReq, wakeReq, partialMode, idle, asleep, dqOe;
    logic        primarySelectN, sleepControlSelect, outputEnableN;
    logic        writeEnableN, lowByteSelectN, highByteSelectN;
    logic [21:0] reqAddr, memAddr;
    logic [15:0] reqData, respData, dqOut, dqIn;
    logic [1:0]  reqByteEn, mask;
    int          error_cnt = 0, comparisons = 0;
    int          selLo, selHi, weLo, slLo, wake;
    bit          booted;

    psc_host #(.DENSITY(64), .CHH_CYC(CHH), .C2LH_CYC(C2LH)) u_dut (
        .clock, .reset, .reqValid, .reqReady, .reqWrite, .reqAddr,
        .reqData, .reqByteEn, .respValid, .respData, .sleepReq, .wakeReq,
        .partialMode, .idle, .asleep, .memAddr, .primarySelectN,
        .sleepControlSelect, .outputEnableN, .writeEnableN,
        .lowByteSelectN, .highByteSelectN, .dqOut, .dqOe, .dqIn);
    psc_psram_model u_mem (.addr(memAddr), .selN(primarySelectN),
        .sleep(sleepControlSelect), .oeN(outputEnableN),
        .weN(writeEnableN), .lbN(lowByteSelectN), .hbN(highByteSelectN),
        .din(dqOe ? dqOut : ~dqOut), .dq(dqIn));

    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string w, input logic [15:0] e, g);
        comparisons++;
        if (g !== e)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic rng(input string w, input int lo, hi, g);
        comparisons++;
        if (g < lo || g > hi)
        begin
            error_cnt++;
            $display("mismatch %s expected %0d..%0d seen %0d", w, lo, hi, g);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Polls a flag between edges; k picks idle, asleep, ready or response.
    task automatic wait_on(input int k, input int lim);
        int n;
        logic [3:0] s;
        n = 0;
        s = {respValid, reqReady, asleep, idle};
        while (s[k] !== 1'b1 && n < lim)
        begin
            @(posedge clock);
            #1;
            s = {respValid, reqReady, asleep, idle};
            n++;
        end
        if (s[k] !== 1'b1)
        begin
            error_cnt++;
            $display("mismatch wait %0d expected done seen timeout", k);
            complete_run();
        end
    endtask

    // The request rises one edge after the last one; it stands until taken.
    task automatic req(input logic w, input logic [21:0] a,
                       input logic [15:0] d, input logic [1:0] be);
        @(posedge clock);
        #1 reqValid = 1'b1;
        {reqWrite, reqAddr, reqData, reqByteEn} = {w, a, d, be};
        wait_on(2, 600);
        @(posedge clock);
        #1 reqValid = 1'b0;
        if (!w) wait_on(3, 100);
        if (!w) chk("read data", d, respData);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Pin watcher: each level's length is judged when the level ends.
    always @(posedge clock)
        if (reset)
        begin
            {selLo, selHi, weLo, slLo, wake} = '0;
            booted = 1'b0;
        end
        else
        begin
            if (primarySelectN && selLo > 0)
            begin
                rng("select low", RC_CYC, HOLD_CYC, selLo);
                chk("we at deselect", 16'h1, {15'h0, writeEnableN});
            end
            if (!primarySelectN && selHi > 0)
                rng("select high", CP_CYC, BIG, selHi);
            if (!primarySelectN && wake > 0)
                rng("wake hold", partialMode ? CHHP_CYC : CHH, BIG, wake);
            selLo = primarySelectN ? 0 : selLo + 1;
            selHi = primarySelectN ? selHi + 1 : 0;
            wake = (primarySelectN && wake > 0) ? wake + 1 : 0;
            if (!writeEnableN)
            begin
                if (weLo == 0) mask = {highByteSelectN, lowByteSelectN};
                chk("mask", {14'h0, mask},
                    {14'h0, highByteSelectN, lowByteSelectN});
                chk("oe in write", 16'h1, {15'h0, outputEnableN});
            end
            else if (weLo > 0)
                rng("write pulse", WP_CYC, HOLD_CYC, weLo);
            weLo = writeEnableN ? 0 : weLo + 1;
            if (!outputEnableN)
                chk("drive in read", 16'h0, {15'h0, dqOe});
            if (sleepControlSelect && slLo > 0)
            begin
                rng("sleep low", booted ? C2LP_CYC : C2LH, BIG, slLo);
                chk("select at wake", 16'h1, {15'h0, primarySelectN});
                booted = 1'b1;
                wake = 1;
            end
            slLo = sleepControlSelect ? 0 : slLo + 1;
        end

    ////////////////////////////////////////////////////////////////////////
    // Lane writes merge; a page read and an aliased random read follow.
    task automatic t_write_read();
        req(1'b1, 22'h000010, 16'h1234, 2'h3);
        req(1'b1, 22'h000011, 16'h5678, 2'h3);
        req(1'b1, 22'h000010, 16'hFFC3, 2'h1);
        req(1'b0, 22'h000010, 16'h12C3, 2'h3);
        req(1'b0, 22'h000011, 16'h5678, 2'h3);
        req(1'b0, 22'h200010, 16'h12C3, 2'h3);
        wait_on(0, 400);
        $display("write_read done");
    endtask

    // Sleep entry and exit in the given retention mode, then data survives.
    task automatic t_sleep(input logic pm);
        partialMode = pm;
        sleepReq = 1'b1;
        wait_on(1, 100);
        sleepReq = 1'b0;
        wakeReq = 1'b1;
        wait_on(0, 700);
        wakeReq = 1'b0;
        req(1'b0, 22'h000011, 16'h5678, 2'h3);
        $display("sleep done");
    endtask

    initial
    begin
        {reqValid, reqWrite, sleepReq, wakeReq, partialMode} = '0;
        {reqAddr, reqData, reqByteEn} = '0;
        reset = 1'b1;
        repeat (10) @(posedge clock);
        #1 reset = 1'b0;
        wait_on(0, C2LH + CHH + 200);
        $display("power_up done");
        t_write_read();
        t_sleep(1'b1);
        t_sleep(1'b0);
        complete_run();
    end
endmodule
`default_nettype wire
